// [rtl/timers_defs.vh]
`ifndef TIMERS_DEFS_VH
`define TIMERS_DEFS_VH

// dual timer register offsets, channel 1 adds the channel stride
`define DT_LOAD_OFS      8'h00
`define DT_VALUE_OFS     8'h04
`define DT_CTRL_OFS      8'h08
`define DT_INTCLR_OFS    8'h0c
`define DT_STATUS_OFS    8'h10
`define DT_CHAN_STRIDE   8'h20

// control field layout
`define DT_CTRL_EN_BIT   0
`define DT_CTRL_MODE_LO  1
`define DT_CTRL_MODE_HI  2

// counter modes
`define MODE_FREE        2'b00
`define MODE_PERIODIC    2'b01
`define MODE_ONESHOT     2'b10

// reset values
`define DT_LOAD_RST      32'hffffffff
`define DT_CTRL_RST      3'h0
`define COUNT_RST        32'h00000000

// sleep clock divider: 2 MHz oscillator over 64
`define SLEEP_DIV        6'd63
`define SLEEP_HALF       6'd31

`endif

// [rtl/down_counter.v]
`timescale 1ns/10ps
`include "timers_defs.vh"

// one programmable 32-bit down-counter with sticky expiry flag
module down_counter (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire        load_we_i,
  input  wire [31:0] load_val_i,
  input  wire        enable_i,
  input  wire [1:0]  mode_i,
  input  wire        clr_i,
  output reg  [31:0] value_o,
  output reg         flag_o
);

  reg halted;
  wire expire = enable_i & ~halted & (value_o == 32'h00000000);

  // count down, act on expiry per mode
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      value_o <= `COUNT_RST;
      halted  <= 1'b0;
    end else if (load_we_i) begin
      value_o <= load_val_i;
      halted  <= 1'b0;
    end else if (expire) begin
      case (mode_i)
        `MODE_PERIODIC: value_o <= load_val_i;
        `MODE_ONESHOT:  halted  <= 1'b1;
        default:        value_o <= 32'hffffffff;
      endcase
    end else if (enable_i & ~halted) begin
      value_o <= value_o - 32'h00000001;
    end
  end

  // sticky flag, set wins over clear
  always @(posedge core_clk_i) begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (expire)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end

endmodule

// [rtl/sleep_and_system_timers.v]
`timescale 1ns/10ps
`include "timers_defs.vh"

module sleep_and_system_timers (
  input  wire        core_clk_i,
  input  wire        rst_i,
  // apb slave for the dual timer
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg         dual_irq0_o,
  output reg         dual_irq1_o,
  // general tick timer
  input  wire        gen_enable_i,
  input  wire [31:0] gen_interval_i,
  input  wire        gen_clear_i,
  output reg         tick_irq_o,
  // wake-up timer
  input  wire        osc_2mhz_i,
  input  wire        wake_load_i,
  input  wire [31:0] wake_value_i,
  input  wire        wake_reload_i,
  input  wire        wake_clear_i,
  output reg         wake_irq_o,
  output reg         wake_up_o,
  output reg         sleep_clk_o
);

  // register offset match within a channel window
  function is_reg;
    input [7:0] addr;
    input [7:0] ofs;
    input       chan;
    begin
      is_reg = (addr == (ofs + (chan ? `DT_CHAN_STRIDE : 8'h00)));
    end
  endfunction

  reg  [31:0] load0;
  reg  [31:0] load1;
  reg  [2:0]  ctrl0;
  reg  [2:0]  ctrl1;
  wire [31:0] value0;
  wire [31:0] value1;
  wire        flag0;
  wire        flag1;

  // access phase completes one cycle after it opens
  wire access = psel_i & penable_i & ~pready_o;
  wire wr     = psel_i & penable_i & pready_o & pwrite_i;
  wire ld0_we = wr & is_reg(paddr_i, `DT_LOAD_OFS, 1'b0);
  wire ld1_we = wr & is_reg(paddr_i, `DT_LOAD_OFS, 1'b1);
  wire clr0   = wr & is_reg(paddr_i, `DT_INTCLR_OFS, 1'b0);
  wire clr1   = wr & is_reg(paddr_i, `DT_INTCLR_OFS, 1'b1);

  // apb handshake, read data and error
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= access;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
      if (access) begin
        if (is_reg(paddr_i, `DT_LOAD_OFS, 1'b0))
          prdata_o <= load0;
        else if (is_reg(paddr_i, `DT_VALUE_OFS, 1'b0))
          prdata_o <= value0;
        else if (is_reg(paddr_i, `DT_CTRL_OFS, 1'b0))
          prdata_o <= {29'h0, ctrl0};
        else if (is_reg(paddr_i, `DT_STATUS_OFS, 1'b0))
          prdata_o <= {31'h0, flag0};
        else if (is_reg(paddr_i, `DT_LOAD_OFS, 1'b1))
          prdata_o <= load1;
        else if (is_reg(paddr_i, `DT_VALUE_OFS, 1'b1))
          prdata_o <= value1;
        else if (is_reg(paddr_i, `DT_CTRL_OFS, 1'b1))
          prdata_o <= {29'h0, ctrl1};
        else if (is_reg(paddr_i, `DT_STATUS_OFS, 1'b1))
          prdata_o <= {31'h0, flag1};
        else if (!is_reg(paddr_i, `DT_INTCLR_OFS, 1'b0) &&
                 !is_reg(paddr_i, `DT_INTCLR_OFS, 1'b1))
          pslverr_o <= 1'b1; // unmapped
      end
    end
  end

  // software writable load and control
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      load0 <= `DT_LOAD_RST;
      load1 <= `DT_LOAD_RST;
      ctrl0 <= `DT_CTRL_RST;
      ctrl1 <= `DT_CTRL_RST;
    end else if (wr) begin
      if (ld0_we)
        load0 <= pwdata_i;
      if (ld1_we)
        load1 <= pwdata_i;
      if (is_reg(paddr_i, `DT_CTRL_OFS, 1'b0))
        ctrl0 <= pwdata_i[2:0];
      if (is_reg(paddr_i, `DT_CTRL_OFS, 1'b1))
        ctrl1 <= pwdata_i[2:0];
    end
  end

  // two independent channels
  down_counter u_chan0 (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_we_i  (ld0_we),
    .load_val_i (ld0_we ? pwdata_i : load0),
    .enable_i   (ctrl0[`DT_CTRL_EN_BIT]),
    .mode_i     (ctrl0[`DT_CTRL_MODE_HI:`DT_CTRL_MODE_LO]),
    .clr_i      (clr0),
    .value_o    (value0),
    .flag_o     (flag0)
  );

  down_counter u_chan1 (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_we_i  (ld1_we),
    .load_val_i (ld1_we ? pwdata_i : load1),
    .enable_i   (ctrl1[`DT_CTRL_EN_BIT]),
    .mode_i     (ctrl1[`DT_CTRL_MODE_HI:`DT_CTRL_MODE_LO]),
    .clr_i      (clr1),
    .value_o    (value1),
    .flag_o     (flag1)
  );

  // interrupt outputs from flops
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      dual_irq0_o <= 1'b0;
      dual_irq1_o <= 1'b0;
    end else begin
      dual_irq0_o <= flag0;
      dual_irq1_o <= flag1;
    end
  end

  // general tick timer
  reg [31:0] gen_count;
  wire       gen_hit = gen_enable_i & (gen_count >= gen_interval_i);

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      gen_count  <= `COUNT_RST;
      tick_irq_o <= 1'b0;
    end else begin
      if (!gen_enable_i || gen_hit)
        gen_count <= `COUNT_RST;
      else
        gen_count <= gen_count + 32'h00000001;
      if (gen_hit)
        tick_irq_o <= 1'b1;
      else if (gen_clear_i)
        tick_irq_o <= 1'b0;
    end
  end

  // oscillator synchroniser and rising edge
  reg osc_s1;
  reg osc_s2;
  reg osc_s3;
  wire osc_rise = osc_s2 & ~osc_s3;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_2mhz_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // divide by 64 into the sleep clock and its tick
  reg [5:0] div;
  wire      sleep_tick = osc_rise & (div == `SLEEP_DIV);

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      div         <= 6'd0;
      sleep_clk_o <= 1'b0;
    end else if (osc_rise) begin
      div         <= div + 6'd1;
      sleep_clk_o <= (div >= `SLEEP_HALF) & (div != `SLEEP_DIV);
    end
  end

  // wake-up timer paced by the sleep tick
  reg [31:0] wake_count;
  reg [31:0] wake_reload_val;
  reg        wake_run;
  wire       wake_exp = wake_run & sleep_tick & (wake_count == 32'h00000001);

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      wake_count      <= `COUNT_RST;
      wake_reload_val <= `COUNT_RST;
      wake_run        <= 1'b0;
    end else if (wake_load_i) begin
      wake_count      <= wake_value_i;
      wake_reload_val <= wake_value_i;
      wake_run        <= (wake_value_i != 32'h00000000);
    end else if (wake_exp) begin
      if (wake_reload_i)
        wake_count <= wake_reload_val;
      else begin
        wake_count <= 32'h00000000;
        wake_run   <= 1'b0;
      end
    end else if (wake_run & sleep_tick) begin
      wake_count <= wake_count - 32'h00000001;
    end
  end

  // sticky interrupt and wake-up, set wins over clear
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      wake_irq_o <= 1'b0;
      wake_up_o  <= 1'b0;
    end else if (wake_exp) begin
      wake_irq_o <= 1'b1;
      wake_up_o  <= 1'b1;
    end else if (wake_clear_i) begin
      wake_irq_o <= 1'b0;
      wake_up_o  <= 1'b0;
    end
  end

endmodule

// [tb/timers_checker_assertions.sv]
`timescale 1ns/10ps
// port checks for the timer group
module timers_checker (
  input logic core_clk_i,
  input logic rst_i,
  input logic psel_i,
  input logic penable_i,
  input logic gen_clear_i,
  input logic wake_clear_i,
  input logic pready_o,
  input logic pslverr_o,
  input logic dual_irq0_o,
  input logic tick_irq_o,
  input logic wake_irq_o,
  input logic wake_up_o,
  input logic sleep_clk_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // bus handshake
  chk_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready late");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  chk_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // sleep clock holds its high level for many core cycles after it rises
  chk_sleep_level: assert property ($rose(sleep_clk_o) |=> sleep_clk_o [*8])
    else $error("sleep clock too fast");
  // expiry flags
  chk_wake_pair: assert property (wake_irq_o == wake_up_o)
    else $error("wake outputs differ");
  chk_wake_sticky: assert property (wake_irq_o && !wake_clear_i |=> wake_irq_o)
    else $error("wake flag lost");
  chk_tick_sticky: assert property (tick_irq_o && !gen_clear_i |=> tick_irq_o)
    else $error("tick flag lost");
  // a clear completes on the ready edge, the irq output falls one edge later
  chk_irq_sticky: assert property (dual_irq0_o && !$past(pready_o) |=> dual_irq0_o)
    else $error("counter flag lost");
  cov_tick: cover property ($rose(tick_irq_o));
  cov_wake: cover property ($rose(wake_irq_o));
  cov_err: cover property (pslverr_o);
endmodule

bind sleep_and_system_timers timers_checker i_timers_checker (.*);

// [tb/cpu_bus_model.sv]
`timescale 1ns/10ps
// processor side of the apb port, one transfer per call
module cpu_bus_model (
  input  logic        core_clk_i,
  input  logic [31:0] rdata_i,
  input  logic        ready_i,
  input  logic        err_i,
  output logic        sel_o = 1'b0,
  output logic        en_o = 1'b0,
  output logic        write_o = 1'b0,
  output logic [7:0]  addr_o = 8'h00,
  output logic [31:0] wdata_o = 32'h0
);
  // setup, access, hold until ready, then release
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge core_clk_i);
    #1;
    sel_o = 1'b1;
    write_o = w;
    addr_o = a;
    wdata_o = d;
    @(posedge core_clk_i);
    #1;
    en_o = 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (!ready_i && n < 16);
    rd = rdata_i;
    er = err_i;
    // no answer within the limit: poison both results
    if (!ready_i) begin
      rd = 'x;
      er = 1'bx;
    end
    #1;
    sel_o = 1'b0;
    en_o = 1'b0;
    addr_o = ~a; // released address and data lines do not keep old value
    wdata_o = ~d;
  endtask
endmodule

// [tb/tb_sleep_and_system_timers.sv]
`timescale 1ns/10ps
module tb_sleep_and_system_timers;
  logic        core_clk_i = 0, rst_i = 1, gen_enable_i = 0, gen_clear_i = 0;
  logic        osc_2mhz_i = 0, wake_load_i = 0, wake_reload_i = 0, wake_clear_i = 0;
  logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic        dual_irq0_o, dual_irq1_o, tick_irq_o, wake_irq_o, wake_up_o, sleep_clk_o;
  logic [7:0]  paddr_i, b;
  logic [31:0] pwdata_i, prdata_o, rd, gen_interval_i = 32'h2, wake_value_i = 32'h0;
  logic [73:0] rows [0:7];
  int          err_count = 0, checks_done = 0, cyc = 0;
  time         t;

  sleep_and_system_timers i_sleep_and_system_timers (.*);
  cpu_bus_model i_cpu_bus_model (.core_clk_i(core_clk_i), .rdata_i(prdata_o),
    .ready_i(pready_o), .err_i(pslverr_o), .sel_o(psel_i), .en_o(penable_i),
    .write_o(pwrite_i), .addr_o(paddr_i), .wdata_o(pwdata_i));

  always #5 core_clk_i = ~core_clk_i;
  always #250 osc_2mhz_i = ~osc_2mhz_i;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_cpu_bus_model.xfer(w, a, d, rd, er);
    chk({31'h0, er === 1'bx}, 32'h0);
  endtask

  task tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask

  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end

  initial begin
    // write, address, data, read data, error
    rows = '{{1'b0, 8'h00, 32'h0, 32'hffffffff, 1'b0}, {1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
             {1'b0, 8'h0c, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h10, 32'h0, 32'h0, 1'b0},
             {1'b0, 8'h40, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h44, 32'h5, 32'h0, 1'b1},
             {1'b1, 8'h20, 32'h1234, 32'h0, 1'b0}, {1'b0, 8'h24, 32'h0, 32'h1234, 1'b0}};
    tick(4);
    rst_i = 0;
    foreach (rows[i]) begin
      apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
      chk({31'h0, er}, {31'h0, rows[i][0]});
      if (!rows[i][73] && !rows[i][0]) chk(rd, rows[i][32:1]);
    end
    // each channel in each mode, other channel must stay quiet
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 3; m++) begin
        b = ch ? 8'h20 : 8'h00;
        apb(1'b1, b, 32'h4);
        apb(1'b1, b + 8'h08, {29'h0, m[1:0], 1'b1});
        tick(10);
        chk({30'h0, dual_irq1_o, dual_irq0_o}, 32'h1 << ch);
        apb(1'b0, b + 8'h04, 32'h0);
        chk(m == 2 ? rd : {31'h0, m ? rd <= 32'h4 : rd > 32'hffff0000}, {31'h0, m != 2});
        apb(1'b1, b + 8'h08, 32'h0);
        chk({30'h0, dual_irq1_o, dual_irq0_o}, 32'h1 << ch);
        apb(1'b1, b + 8'h0c, 32'h0);
        tick(2);
        chk({30'h0, dual_irq1_o, dual_irq0_o}, 32'h0);
      end
    end
    // general tick, interval 2
    gen_enable_i = 1;
    tick(2);
    chk({31'h0, tick_irq_o}, 32'h0);
    tick(4);
    chk({31'h0, tick_irq_o}, 32'h1);
    gen_enable_i = 0;
    gen_clear_i = 1;
    tick(2);
    gen_clear_i = 0;
    chk({31'h0, tick_irq_o}, 32'h0);
    // sleep clock period is 64 oscillator periods
    @(posedge sleep_clk_o);
    t = $time;
    @(posedge sleep_clk_o);
    chk(32'($time - t), 32'd32000);
    tick(1);
    // one-shot wake of two sleep ticks
    wake_value_i = 32'h2;
    wake_load_i = 1;
    tick(1);
    wake_load_i = 0;
    #30000 chk({31'h0, wake_irq_o}, 32'h0);
    #36000 chk({30'h0, wake_irq_o, wake_up_o}, 32'h3);
    wake_clear_i = 1;
    tick(1);
    wake_clear_i = 0;
    #70000 chk({31'h0, wake_irq_o}, 32'h0);
    // auto-reload of one sleep tick
    wake_value_i = 32'h1;
    wake_reload_i = 1;
    wake_load_i = 1;
    tick(1);
    wake_load_i = 0;
    #34000 chk({31'h0, wake_irq_o}, 32'h1);
    wake_clear_i = 1;
    tick(1);
    wake_clear_i = 0;
    #34000 chk({31'h0, wake_irq_o}, 32'h1);
    // mid-run reset clears flags and divider, returns registers to their reset values
    rst_i = 1;
    tick(4);
    chk({29'h0, tick_irq_o, wake_irq_o, wake_up_o}, 32'h0);
    chk({31'h0, sleep_clk_o}, 32'h0);
    rst_i = 0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hffffffff);
    results();
  end
endmodule
